// [hw/eag_defs.svh]
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH
// What this block does
// [RULE1] Accumulator mode: one byte, acts on accumulator.
// [RULE2] Immediate mode: second byte is the operand.
// [RULE3] Absolute: byte two low, byte three high.
// [RULE4] Zero page: byte two low, high zero.
// [RULE5] Zero page indexed: add index, no carry.
// [RULE6] Absolute indexed: add index to 16-bit base.
// [RULE7] Implied mode: opcode alone names the operand.
// [RULE8] Relative mode only for conditional branches.
// [RULE9] Signed offset added to advanced program counter.
// [RULE10] Indexed indirect: byte plus X, page-zero pointer.
// [RULE11] Indirect indexed: pointer low plus Y.
// [RULE12] Indirect indexed: low carry into high byte.
// [RULE13] Absolute indirect: pointer pair loads program counter.
// [RULE14] Add with carry into accumulator.
// [RULE15] Subtract with borrow from accumulator.
// [RULE16] Instructions setting carry, decimal, interrupt disable.
// [RULE17] Absolute indexed carries into high byte.
// [RULE18] Branch offset sign-extended across 16 bits.

// Addressing mode field, opcode bits 7 to 4.
`define EAG_M_ACC     4'h0
`define EAG_M_IMM     4'h1
`define EAG_M_IMP     4'h2
`define EAG_M_ABS     4'h3
`define EAG_M_ZP      4'h4
`define EAG_M_ZPX     4'h5
`define EAG_M_ZPY     4'h6
`define EAG_M_ABSX    4'h7
`define EAG_M_ABSY    4'h8
`define EAG_M_REL     4'h9
`define EAG_M_INDX    4'hA
`define EAG_M_INDY    4'hB
`define EAG_M_IND     4'hC

// Operation field, opcode bits 3 to 0.
`define EAG_O_ADC     4'h0
`define EAG_O_SUBTRACT_WITH_BORROW 4'h1
`define EAG_O_LDA     4'h2
`define EAG_O_LDX     4'h3
`define EAG_O_LDY     4'h4
`define EAG_O_STA     4'h5
`define EAG_O_SET_CARRY_FLAG        4'h6
`define EAG_O_SET_DECIMAL_FLAG      4'h7
`define EAG_O_SET_INTERRUPT_DISABLE 4'h8
`define EAG_O_CLC     4'h9
`define EAG_O_JMP     4'hA
`define EAG_O_ASL     4'hB
`define EAG_O_BCS     4'hC
`define EAG_O_BCC     4'hD
`define EAG_O_BEQ     4'hE
`define EAG_O_BNE     4'hF

`define EAG_RESET_VEC 16'hFFFC
`define EAG_ZERO_PAGE 8'h00
`define EAG_ONE16     16'h0001
`define EAG_ONE8      8'h01
`endif

// [hw/eag_pkg.sv]
package eag_pkg;

  typedef enum logic [2:0] {
    S_OP   = 3'b000,
    S_B2   = 3'b001,
    S_B3   = 3'b010,
    S_PLO  = 3'b011,
    S_PHI  = 3'b100,
    S_DATA = 3'b101,
    S_WR   = 3'b110,
    S_EXEC = 3'b111
  } eag_state_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } eag_bus_out_type;

  typedef struct packed {
    logic       ready;
    logic [7:0] rdata;
  } eag_bus_in_type;

  typedef struct packed {
    logic n;
    logic v;
    logic d;
    logic i;
    logic z;
    logic c;
  } eag_flags_type;

  // Byte add that keeps the carry in bit 8.
  function automatic logic [8:0] eag_add8(input logic [7:0] a,
                                          input logic [7:0] b);
    eag_add8 = {1'b0, a} + {1'b0, b};
  endfunction

endpackage

// [hw/eag_alu.sv]
module eag_alu
  import eag_pkg::*;
(
  input  wire logic [7:0] acc,
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  input  wire logic       subtract,
  output logic      [7:0] result,
  output logic            carry_out,
  output logic            overflow
);

  logic [7:0] m_eff;
  logic [8:0] sum;

  // Borrow is the inverted carry, so subtraction reuses the adder.
  // [RULE14] [RULE15] Binary add or subtract.
  assign m_eff     = subtract ? ~operand : operand;
  assign sum       = eag_add8(acc, m_eff) + {8'h00, carry_in};
  assign result    = sum[7:0];
  assign carry_out = sum[8];
  assign overflow  = (acc[7] == m_eff[7]) && (sum[7] != acc[7]);

endmodule // eag_alu

// [hw/eag_branch.sv]
`include "eag_defs.svh"
module eag_branch
  import eag_pkg::*;
(
  input  wire logic [15:0]   pc_next,
  input  wire logic [7:0]    offset,
  input  wire logic [3:0]    op,
  input  wire eag_flags_type flags,
  output logic      [15:0]   target,
  output logic               taken
);

  // [RULE9] [RULE18] Sign-extended full-width target.
  assign target = pc_next + {{8{offset[7]}}, offset};

  // [RULE8] Conditional branches only.
  always_comb
  begin
    case (op)
      `EAG_O_BCS: taken = flags.c;
      `EAG_O_BCC: taken = !flags.c;
      `EAG_O_BEQ: taken = flags.z;
      `EAG_O_BNE: taken = !flags.z;
      default:    taken = 1'b0;
    endcase
  end

endmodule // eag_branch

// [hw/eag_top.sv]
`include "eag_defs.svh"
module eag_top
  import eag_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire eag_bus_in_type  bus_in,
  output eag_bus_out_type      bus_out,
  output logic [7:0]           acc,
  output logic [7:0]           idx_x,
  output logic [7:0]           idx_y,
  output logic [15:0]          pc,
  output eag_flags_type        flags,
  output logic [15:0]          eff_addr
);

  ////////////////////////////////////////////////////////////////////////////

  eag_state_type state_q;
  logic [7:0]    opcode_q;
  logic [7:0]    b2_q;
  logic [7:0]    lo_q;
  logic [7:0]    operand_q;
  logic [15:0]   addr_q;
  logic [15:0]   pc_q;
  logic [15:0]   ea_q;
  logic          vec_q;
  logic [7:0]    a_q;
  logic [7:0]    x_q;
  logic [7:0]    y_q;
  eag_flags_type flags_q;

  logic [3:0]    mode;
  logic [3:0]    op;
  logic [3:0]    new_mode;
  logic [7:0]    rd;
  logic          use_y;
  logic [7:0]    idx;
  logic [8:0]    b2_idx_sum;
  logic [8:0]    indy_sum;
  logic [15:0]   base16;
  logic [15:0]   base_idx;
  logic [15:0]   indy_ea;
  logic          is_store;
  logic [7:0]    alu_result;
  logic          alu_carry;
  logic          alu_overflow;
  logic [15:0]   br_target;
  logic          br_taken;
  logic          data_mode;

  ////////////////////////////////////////////////////////////////////////////

  assign mode     = opcode_q[7:4];
  assign op       = opcode_q[3:0];
  assign new_mode = bus_in.rdata[7:4];
  assign rd       = bus_in.rdata;
  assign use_y    = (mode == `EAG_M_ZPY) || (mode == `EAG_M_ABSY) ||
                    (mode == `EAG_M_INDY);
  assign idx      = use_y ? y_q : x_q;
  assign is_store = (op == `EAG_O_STA);

  // [RULE5] [RULE10] Page-zero sum, carry dropped.
  assign b2_idx_sum = eag_add8(rd, idx);

  // [RULE3] Byte two low, byte three high.
  assign base16 = {rd, b2_q};

  // [RULE6] [RULE17] Index added across 16 bits.
  assign base_idx = base16 + {8'h00, idx};

  // [RULE11] [RULE12] Pointer low plus Y, carry up.
  assign indy_sum = eag_add8(lo_q, y_q);
  assign indy_ea  = {rd + {7'h00, indy_sum[8]}, indy_sum[7:0]};

  assign data_mode = (mode != `EAG_M_ACC) && (mode != `EAG_M_IMP) &&
                     (mode != `EAG_M_REL) && (mode != `EAG_M_IND);

  ////////////////////////////////////////////////////////////////////////////

  eag_alu u_alu (
    .acc       (a_q),
    .operand   (operand_q),
    .carry_in  (flags_q.c),
    .subtract  (op == `EAG_O_SUBTRACT_WITH_BORROW),
    .result    (alu_result),
    .carry_out (alu_carry),
    .overflow  (alu_overflow)
  );

  eag_branch u_branch (
    .pc_next (pc_q),
    .offset  (b2_q),
    .op      (op),
    .flags   (flags_q),
    .target  (br_target),
    .taken   (br_taken)
  );

  ////////////////////////////////////////////////////////////////////////////

  // Every state except execute holds one memory access open until ready.
  assign bus_out.req   = (state_q != S_EXEC);
  assign bus_out.we    = (state_q == S_WR);
  assign bus_out.addr  = addr_q;
  assign bus_out.wdata = a_q;

  assign acc      = a_q;
  assign idx_x    = x_q;
  assign idx_y    = y_q;
  assign pc       = pc_q;
  assign flags    = flags_q;
  assign eff_addr = ea_q;

  ////////////////////////////////////////////////////////////////////////////

  // Sequencer: fetches opcode and address bytes and forms the address.
  // The pointer walk is shared with the reset vector fetch to save states.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q   <= S_PLO;
      addr_q    <= `EAG_RESET_VEC;
      vec_q     <= 1'b1;
      pc_q      <= 16'h0000;
      opcode_q  <= 8'h00;
      b2_q      <= 8'h00;
      lo_q      <= 8'h00;
      operand_q <= 8'h00;
      ea_q      <= 16'h0000;
    end
    else if (ce)
    begin
      case (state_q)
        S_OP:
        begin
          if (bus_in.ready)
          begin
            opcode_q <= rd;
            pc_q     <= pc_q + `EAG_ONE16;
            // [RULE1] [RULE7] No operand bytes fetched.
            if ((new_mode == `EAG_M_ACC) || (new_mode == `EAG_M_IMP))
            begin
              state_q <= S_EXEC;
            end
            else
            begin
              state_q <= S_B2;
              addr_q  <= pc_q + `EAG_ONE16;
            end
          end
        end
        S_B2:
        begin
          if (bus_in.ready)
          begin
            b2_q <= rd;
            pc_q <= pc_q + `EAG_ONE16;
            case (mode)
              `EAG_M_IMM:
              begin
                // [RULE2] Byte two is the operand.
                operand_q <= rd;
                state_q   <= S_EXEC;
              end
              `EAG_M_REL:
              begin
                state_q <= S_EXEC;
              end
              `EAG_M_ZP:
              begin
                // [RULE4] High byte forced to zero.
                ea_q    <= {`EAG_ZERO_PAGE, rd};
                addr_q  <= {`EAG_ZERO_PAGE, rd};
                state_q <= is_store ? S_WR : S_DATA;
              end
              `EAG_M_ZPX, `EAG_M_ZPY:
              begin
                // [RULE5] Stays in page zero.
                ea_q    <= {`EAG_ZERO_PAGE, b2_idx_sum[7:0]};
                addr_q  <= {`EAG_ZERO_PAGE, b2_idx_sum[7:0]};
                state_q <= is_store ? S_WR : S_DATA;
              end
              `EAG_M_INDX:
              begin
                // [RULE10] Pointer is byte two plus X.
                addr_q  <= {`EAG_ZERO_PAGE, b2_idx_sum[7:0]};
                state_q <= S_PLO;
              end
              `EAG_M_INDY:
              begin
                addr_q  <= {`EAG_ZERO_PAGE, rd};
                state_q <= S_PLO;
              end
              default:
              begin
                addr_q  <= pc_q + `EAG_ONE16;
                state_q <= S_B3;
              end
            endcase
          end
        end
        S_B3:
        begin
          if (bus_in.ready)
          begin
            pc_q <= pc_q + `EAG_ONE16;
            case (mode)
              `EAG_M_ABS:
              begin
                if (op == `EAG_O_JMP)
                begin
                  pc_q    <= base16;
                  addr_q  <= base16;
                  state_q <= S_OP;
                end
                else
                begin
                  ea_q    <= base16;
                  addr_q  <= base16;
                  state_q <= is_store ? S_WR : S_DATA;
                end
              end
              `EAG_M_ABSX, `EAG_M_ABSY:
              begin
                ea_q    <= base_idx;
                addr_q  <= base_idx;
                state_q <= is_store ? S_WR : S_DATA;
              end
              `EAG_M_IND:
              begin
                addr_q  <= base16;
                state_q <= S_PLO;
              end
              default:
              begin
                addr_q  <= pc_q + `EAG_ONE16;
                state_q <= S_OP;
              end
            endcase
          end
        end
        S_PLO:
        begin
          if (bus_in.ready)
          begin
            lo_q    <= rd;
            state_q <= S_PHI;
            // Page-zero pointers wrap inside page zero.
            if (vec_q || (mode == `EAG_M_IND))
            begin
              addr_q <= addr_q + `EAG_ONE16;
            end
            else
            begin
              addr_q <= {`EAG_ZERO_PAGE, addr_q[7:0] + `EAG_ONE8};
            end
          end
        end
        S_PHI:
        begin
          if (bus_in.ready)
          begin
            if (vec_q || (mode == `EAG_M_IND))
            begin
              // [RULE13] Pointer pair loads program counter.
              pc_q    <= {rd, lo_q};
              addr_q  <= {rd, lo_q};
              vec_q   <= 1'b0;
              state_q <= S_OP;
            end
            else if (mode == `EAG_M_INDY)
            begin
              // [RULE12] Carry into high byte.
              ea_q    <= indy_ea;
              addr_q  <= indy_ea;
              state_q <= is_store ? S_WR : S_DATA;
            end
            else
            begin
              ea_q    <= {rd, lo_q};
              addr_q  <= {rd, lo_q};
              state_q <= is_store ? S_WR : S_DATA;
            end
          end
        end
        S_DATA:
        begin
          if (bus_in.ready)
          begin
            operand_q <= rd;
            state_q   <= S_EXEC;
          end
        end
        S_WR:
        begin
          if (bus_in.ready)
          begin
            addr_q  <= pc_q;
            state_q <= S_OP;
          end
        end
        S_EXEC:
        begin
          state_q <= S_OP;
          // [RULE8] [RULE9] Taken branch loads target.
          if ((mode == `EAG_M_REL) && br_taken)
          begin
            pc_q   <= br_target;
            addr_q <= br_target;
          end
          else
          begin
            addr_q <= pc_q;
          end
        end
        default:
        begin
          state_q <= S_OP;
          addr_q  <= pc_q;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Data registers change only in the execute cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      a_q <= 8'h00;
      x_q <= 8'h00;
      y_q <= 8'h00;
    end
    else if (ce && (state_q == S_EXEC))
    begin
      case (op)
        `EAG_O_ADC, `EAG_O_SUBTRACT_WITH_BORROW:
        begin
          // [RULE14] [RULE15] Result into accumulator.
          if (data_mode)
          begin
            a_q <= alu_result;
          end
        end
        `EAG_O_LDA:
        begin
          if (data_mode)
          begin
            a_q <= operand_q;
          end
        end
        `EAG_O_LDX:
        begin
          if (data_mode)
          begin
            x_q <= operand_q;
          end
        end
        `EAG_O_LDY:
        begin
          if (data_mode)
          begin
            y_q <= operand_q;
          end
        end
        `EAG_O_ASL:
        begin
          // [RULE1] Shift the accumulator in place.
          if (mode == `EAG_M_ACC)
          begin
            a_q <= {a_q[6:0], 1'b0};
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Interrupts are masked out of reset, as the start-up code expects.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flags_q   <= '0;
      flags_q.i <= 1'b1;
    end
    else if (ce && (state_q == S_EXEC))
    begin
      case (op)
        `EAG_O_ADC, `EAG_O_SUBTRACT_WITH_BORROW:
        begin
          if (data_mode)
          begin
            flags_q.c <= alu_carry;
            flags_q.v <= alu_overflow;
            flags_q.z <= (alu_result == 8'h00);
            flags_q.n <= alu_result[7];
          end
        end
        `EAG_O_LDA, `EAG_O_LDX, `EAG_O_LDY:
        begin
          if (data_mode)
          begin
            flags_q.z <= (operand_q == 8'h00);
            flags_q.n <= operand_q[7];
          end
        end
        `EAG_O_ASL:
        begin
          if (mode == `EAG_M_ACC)
          begin
            flags_q.c <= a_q[7];
            flags_q.z <= (a_q[6:0] == 7'h00);
            flags_q.n <= a_q[6];
          end
        end
        // [RULE16] Flag set instructions, then clear carry.
        `EAG_O_SET_CARRY_FLAG:
        begin
          if (mode == `EAG_M_IMP)
          begin
            flags_q.c <= 1'b1;
          end
        end
        `EAG_O_SET_DECIMAL_FLAG:
        begin
          if (mode == `EAG_M_IMP)
          begin
            flags_q.d <= 1'b1;
          end
        end
        `EAG_O_SET_INTERRUPT_DISABLE:
        begin
          if (mode == `EAG_M_IMP)
          begin
            flags_q.i <= 1'b1;
          end
        end
        `EAG_O_CLC:
        begin
          if (mode == `EAG_M_IMP)
          begin
            flags_q.c <= 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
  end

endmodule // eag_top

// [sim/eag_props.sv]
module eag_props
  import eag_pkg::*;
(
  input wire logic            clk,
  input wire logic            rst,
  input wire logic            ce,
  input wire eag_bus_in_type  bus_in,
  input wire eag_bus_out_type bus_out,
  input wire logic [7:0]      acc,
  input wire logic [7:0]      idx_x,
  input wire logic [7:0]      idx_y,
  input wire logic [15:0]     pc,
  input wire eag_flags_type   flags,
  input wire logic [15:0]     eff_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_boot;
    $fell(rst) |-> bus_out.addr == 16'hFFFC && bus_out.req &&
      !bus_out.we && pc == 16'h0000 && flags.i;
  endproperty
  a_boot: assert property (p_boot)
    else $error("reset does not start at the vector");
  property p_hold;
    bus_out.req && !(bus_in.ready && ce) |=>
      $stable(bus_out.addr) && $stable(bus_out.we);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address moved during a wait");
  property p_freeze;
    !ce |=> $stable(pc) && $stable(acc) && $stable(eff_addr);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved with enable low");
  property p_exec;
    !bus_out.req && ce |=> bus_out.req;
  endproperty
  a_exec: assert property (p_exec)
    else $error("execute cycle longer than one");
  property p_ea;
    $changed(eff_addr) |-> bus_out.addr == eff_addr;
  endproperty
  a_ea: assert property (p_ea)
    else $error("data access not at effective address");
  property p_store;
    bus_out.we |-> bus_out.addr == eff_addr && bus_out.wdata == acc;
  endproperty
  a_store: assert property (p_store)
    else $error("store address or data wrong");
  property p_keep;
    !$fell(flags.d) && !$fell(flags.i);
  endproperty
  a_keep: assert property (p_keep)
    else $error("a set-only flag fell");
  property p_acc;
    $changed(acc) || $changed(flags.c) |-> !$past(bus_out.req);
  endproperty
  a_acc: assert property (p_acc)
    else $error("accumulator changed outside execute");
endmodule // eag_props

// [sim/eag_mem.sv]
module eag_mem
  import eag_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            slow,
  input  wire eag_bus_out_type bus_out,
  output eag_bus_in_type       bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem_q [0:65535];
  logic       wait_q;
  logic [7:0] last_q;
  initial
  begin
    for (int k = 0; k < 65536; k++)
      mem_q[k] = 8'h00;
    wait_q = 1'b0;
    last_q = 8'h00;
  end
  ////////////////////////////////////////
  // Slow mode answers every other cycle, so waits of one cycle occur.
  assign bus_in.ready = slow ? wait_q : 1'b1;
  // Idle data is the inverse of the last read, so a late sample shows.
  assign bus_in.rdata = (bus_in.ready && bus_out.req && !bus_out.we) ?
                        mem_q[bus_out.addr] : ~last_q;
  always @(posedge clk)
  begin
    wait_q <= ~wait_q;
    if (bus_out.req && bus_in.ready && bus_out.we)
      mem_q[bus_out.addr] <= bus_out.wdata;
    if (bus_out.req && bus_in.ready && !bus_out.we)
      last_q <= mem_q[bus_out.addr];
  end
endmodule // eag_mem

// [sim/testbench.sv]
module testbench
  import eag_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk;
  logic            rst;
  logic            ce;
  logic            slow;
  eag_bus_in_type  bus_in;
  eag_bus_out_type bus_out;
  logic [7:0]      acc;
  logic [7:0]      idx_x;
  logic [7:0]      idx_y;
  logic [15:0]     pc;
  eag_flags_type   flags;
  logic [15:0]     eff_addr;
  int              n_errors;
  int              tests_run;
  int              cycles;
  logic [7:0]      q[$];
  eag_top uut (.clk(clk), .rst(rst), .ce(ce), .bus_in(bus_in),
    .bus_out(bus_out), .acc(acc), .idx_x(idx_x), .idx_y(idx_y),
    .pc(pc), .flags(flags), .eff_addr(eff_addr));
  eag_mem mem (.clk(clk), .slow(slow), .bus_out(bus_out), .bus_in(bus_in));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The ceiling lies far above all five program runs put together.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic chk_b(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_w(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic load(input logic [15:0] a);
    foreach (q[k])
      mem.mem_q[a + 16'(k)] = q[k];
  endtask
  task automatic boot(input logic [15:0] v);
    mem.mem_q[16'hFFFC] = v[7:0];
    mem.mem_q[16'hFFFD] = v[15:8];
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
  endtask
  // Each program ends in a jump to itself; its opcode fetch means done.
  task automatic run(input logic [15:0] l, input logic tog);
    int k;
    k = 0;
    while (!(bus_out.req === 1'b1 && bus_out.addr === l) && k < 3000)
    begin
      @(negedge clk);
      if (tog)
        ce = ~ce;
      k++;
    end
    ce = 1'b1;
    chk_w("stop", l, bus_out.addr);
  endtask
  ////////////////////////////////////////
  task automatic t_arith();
    q = '{8'h26, 8'h12, 8'h5A, 8'h10, 8'h10, 8'h11, 8'h0B, 8'h27,
          8'h28, 8'h13, 8'hFF, 8'h70, 8'hF0, 8'h12, 8'h3A, 8'h0E, 8'h02};
    load(16'h0200);
    mem.mem_q[16'h13EF] = 8'h21;
    boot(16'h0200);
    chk_b("acc reset", 8'h00, acc);
    chk_b("i reset", 8'h01, {7'h00, flags.i});
    run(16'h020E, 1'b0);
    chk_b("acc", 8'h81, acc);
    chk_w("ea", 16'h13EF, eff_addr);
    chk_b("carry", 8'h00, {7'h00, flags.c});
    chk_b("dec", 8'h01, {7'h00, flags.d});
    chk_b("flags", 8'h3C, {2'h0, flags});
    chk_b("x", 8'hFF, idx_x);
  endtask
  task automatic t_zpage();
    q = '{8'h12, 8'h77, 8'h13, 8'hF0, 8'h55, 8'h30, 8'h45, 8'h81,
          8'h35, 8'h34, 8'h12, 8'h0B, 8'h3A, 8'h0C, 8'h04};
    load(16'h0400);
    boot(16'h0400);
    run(16'h040C, 1'b1);
    chk_b("zpx", 8'h77, mem.mem_q[16'h0020]);
    chk_b("no carry", 8'h00, mem.mem_q[16'h0120]);
    chk_b("zp", 8'h77, mem.mem_q[16'h0081]);
    chk_b("abs", 8'h77, mem.mem_q[16'h1234]);
    chk_b("shift", 8'hEE, acc);
  endtask
  task automatic t_indirect();
    q = '{8'h13, 8'h01, 8'hA2, 8'hFE, 8'h35, 8'h00, 8'h60, 8'h14,
          8'h10, 8'hB2, 8'h40, 8'h3A, 8'h0B, 8'h05};
    load(16'h0500);
    mem.mem_q[16'h00FF] = 8'h56;
    mem.mem_q[16'h0000] = 8'h34;
    mem.mem_q[16'h3456] = 8'h99;
    mem.mem_q[16'h0040] = 8'hF8;
    mem.mem_q[16'h0041] = 8'h20;
    mem.mem_q[16'h2108] = 8'h3C;
    mem.mem_q[16'h2008] = 8'h11;
    slow = 1'b1;
    boot(16'h0500);
    run(16'h050B, 1'b0);
    slow = 1'b0;
    chk_b("ind x", 8'h99, mem.mem_q[16'h6000]);
    chk_w("ea", 16'h2108, eff_addr);
    chk_b("ind y", 8'h3C, acc);
    chk_b("y", 8'h10, idx_y);
  endtask
  // Zero page and absolute with Y, then both zero-flag branches.
  task automatic t_index();
    q = '{8'h14, 8'h05, 8'h12, 8'h40, 8'h65, 8'hFE, 8'h82, 8'hFE,
          8'h12, 8'h9E, 8'h03, 8'h3A, 8'h0B, 8'h06, 8'h9F, 8'h03,
          8'h3A, 8'h10, 8'h06};
    load(16'h0600);
    mem.mem_q[16'h1303] = 8'h00;
    boot(16'h0600);
    run(16'h0610, 1'b0);
    chk_b("zpy", 8'h40, mem.mem_q[16'h0003]);
    chk_b("zpy carry", 8'h00, mem.mem_q[16'h0103]);
    chk_w("ea y", 16'h1303, eff_addr);
    chk_b("zero", 8'h01, {7'h00, flags.z});
    chk_b("acc y", 8'h00, acc);
    chk_b("y", 8'h05, idx_y);
  endtask
  // Traps loop at wrong targets, so a wrong branch never reaches 4000.
  task automatic t_branch();
    q = '{8'h29, 8'h9D, 8'h80, 8'h3A, 8'h13, 8'h03, 8'h00, 8'hCA,
          8'h00, 8'h30};
    load(16'h0310);
    q = '{8'h26, 8'h9D, 8'h05, 8'h9C, 8'h7F, 8'h3A, 8'h9B, 8'h02};
    load(16'h0293);
    q = '{8'h3A, 8'h9B, 8'h02};
    load(16'h029B);
    q = '{8'h00, 8'h40};
    load(16'h3000);
    q = '{8'h3A, 8'h00, 8'h40};
    load(16'h4000);
    boot(16'h0310);
    run(16'h4000, 1'b0);
    chk_w("pc", 16'h4000, pc);
  endtask
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    slow = 1'b0;
    n_errors = 0;
    tests_run = 0;
    cycles = 0;
    repeat (5) @(negedge clk);
    t_arith();
    t_zpage();
    t_indirect();
    t_branch();
    t_index();
    give_verdict();
  end
endmodule // testbench

bind eag_top eag_props chk (.clk(clk), .rst(rst), .ce(ce),
  .bus_in(bus_in), .bus_out(bus_out), .acc(acc), .idx_x(idx_x),
  .idx_y(idx_y), .pc(pc), .flags(flags), .eff_addr(eff_addr));
